/* File: cc_event_interrupt_regs.sv */
`timescale 1ns/1ps
`include "cc_event_cfg.svh"

// Operation
// - Mask bit 4 gates Rp change interrupt; 1 suppresses; resets to 1.
// - Mask bit 3 gates role change interrupt; 1 suppresses; resets to 1.
// - Mask bit 2 gates orientation found interrupt; 1 suppresses; resets to 1.
// - Mask bit 1 gates debug accessory interrupt; 1 suppresses; resets to 1.
// - Mask bit 0 gates audio accessory interrupt; 1 suppresses; resets to 1.
// - Rp advertisement change while sink sets status bit 4, updates Rp field.
// - Role change sets status bit 3 and updates role field; read clears.
// - Orientation found sets status bit 2, updates orientation field; read clears.
// - Debug accessory sets status bit 1, role field becomes 100; read clears.
// - Audio accessory sets status bit 0, role field becomes 011; read clears.
// - Role codes: none, source, sink, audio, debug; 101 to 111 reserved.
// - Orientation codes: none, normal, reversed; 11 reserved.

module cc_event_interrupt_regs (
   input  wire logic                    core_clk_i,
   input  wire logic                    nrst_i,
   input  wire logic                    link_clk_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   input  wire logic [7:0]              reg_addr_i,
   input  wire logic [7:0]              reg_wdata_i,
   output logic      [7:0]              reg_rdata_o,
   output logic                         reg_rvalid_o,
   output logic                         reg_busy_o,
   input  wire logic                    rp_change_evt_i,
   input  wire logic [1:0]              rp_adv_i,
   input  wire logic                    role_change_evt_i,
   input  wire cc_event_pkg::role_e     role_i,
   input  wire logic                    orient_evt_i,
   input  wire cc_event_pkg::orient_e   orient_i,
   input  wire logic                    debug_evt_i,
   input  wire logic                    audio_evt_i,
   output logic      [1:0]              attach_rp_o,
   output cc_event_pkg::role_e          attach_role_o,
   output cc_event_pkg::orient_e        attach_orient_o,
   output logic                         int_n_o
);
   import cc_event_pkg::*;

   // Reads go through a function; only the core side calls it and decodes the address
   function automatic reg_byte_t read_map(input logic [7:0] addr,
                                          input logic [4:0] mask,
                                          input logic [4:0] status);
      reg_byte_t val;
      val = 8'h00;
      unique case (addr)
         `OFS_FIXED_A:      val = `RST_FIXED_A;
         `OFS_FIXED_B:      val = `RST_FIXED_B;
         `OFS_FIXED_C:      val = `RST_FIXED_C;
         `OFS_FIXED_D:      val = `RST_FIXED_D;
         `OFS_FIXED_E:      val = `RST_FIXED_E;
         `OFS_EVENT_MASK:   val = {3'h0, mask};
         `OFS_EVENT_STATUS: val = {3'h0, status};
         default:           val = 8'h00;
      endcase
      return val;
   endfunction

   // Accessory events override a simultaneous role report
   function automatic role_e role_update(input role_e cur,
                                         input role_e reported,
                                         input logic  dbg,
                                         input logic  aud,
                                         input logic  chg);
      role_e val;
      val = cur;
      if (dbg) begin
         val = ROLE_DEBUG;
      end else if (aud) begin
         val = ROLE_AUDIO;
      end else if (chg) begin
         val = reported;
      end
      return val;
   endfunction

   // Pending bits that may drive the pin; a mask bit of 1 hides its event
   function automatic logic [4:0] unmasked(input logic [4:0] status,
                                           input logic [4:0] mask);
      return status & ~mask;
   endfunction

   // Link domain
   logic             link_rst_meta_reg;
   logic             link_rst_n_reg;
   link_state_e      link_state_reg;
   logic             req_take;
   logic             req_tgl_reg;
   logic             req_we_reg;
   logic [7:0]       req_addr_reg;
   logic [7:0]       req_wdata_reg;
   logic             ack_meta_reg;
   logic             ack_sync_reg;
   logic             ack_seen_reg;
   logic             ack_edge;

   // Core domain
   logic             core_rst_meta_reg;
   logic             core_rst_n_reg;
   logic             req_meta_reg;
   logic             req_sync_reg;
   logic             req_seen_reg;
   logic             req_edge;
   logic             ack_tgl_reg;
   reg_byte_t        core_rdata_reg;
   logic [4:0]       mask_reg;
   logic [4:0]       status_reg;
   logic [4:0]       status_next;
   logic [4:0]       event_set;
   logic             status_read;
   logic             mask_write;

   assign ack_edge = ack_sync_reg ^ ack_seen_reg;
   assign req_edge = req_sync_reg ^ req_seen_reg;

   // Only one access in flight; requests held while busy are dropped
   assign req_take = (link_state_reg == LINK_IDLE) && (reg_wr_i || reg_rd_i);

   // Reset asserts at once but each domain leaves it on its own edge,
   // so no register sees the release inside its setup window
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         link_rst_meta_reg <= 1'b0;
         link_rst_n_reg    <= 1'b0;
      end else begin
         link_rst_meta_reg <= 1'b1;
         link_rst_n_reg    <= link_rst_meta_reg;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_rst_meta_reg <= 1'b0;
         core_rst_n_reg    <= 1'b0;
      end else begin
         core_rst_meta_reg <= 1'b1;
         core_rst_n_reg    <= core_rst_meta_reg;
      end
   end

   // Access sequencing on the link side
   always_ff @(posedge link_clk_i or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         link_state_reg <= LINK_IDLE;
      end else begin
         unique case (link_state_reg)
            LINK_IDLE: begin
               if (req_take) begin
                  link_state_reg <= LINK_WAIT;
               end
            end
            LINK_WAIT: begin
               if (ack_edge) begin
                  link_state_reg <= LINK_IDLE;
               end
            end
         endcase
      end
   end

   // Request fields hold still until the acknowledge returns, so the core
   // side may read them after the toggle has crossed
   always_ff @(posedge link_clk_i or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         req_we_reg    <= 1'b0;
         req_addr_reg  <= 8'h00;
         req_wdata_reg <= 8'h00;
      end else if (req_take) begin
         req_we_reg    <= reg_wr_i;
         req_addr_reg  <= reg_addr_i;
         req_wdata_reg <= reg_wdata_i;
      end
   end

   always_ff @(posedge link_clk_i or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         req_tgl_reg <= 1'b0;
      end else if (req_take) begin
         req_tgl_reg <= ~req_tgl_reg;
      end
   end

   // Acknowledge toggle crossing into the link clock
   always_ff @(posedge link_clk_i or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
      end else begin
         ack_meta_reg <= ack_tgl_reg;
         ack_sync_reg <= ack_meta_reg;
         ack_seen_reg <= ack_sync_reg;
      end
   end

   // Core read data is stable from the acknowledge toggle, written in the same core cycle, until the next request
   always_ff @(posedge link_clk_i or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         reg_rdata_o <= 8'h00;
      end else if (ack_edge && !req_we_reg) begin
         reg_rdata_o <= core_rdata_reg;
      end
   end

   always_ff @(posedge link_clk_i or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= ack_edge && !req_we_reg;
      end
   end

   always_ff @(posedge link_clk_i or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         reg_busy_o <= 1'b0;
      end else if (link_state_reg == LINK_IDLE) begin
         reg_busy_o <= req_take;
      end else begin
         reg_busy_o <= !ack_edge;
      end
   end

   // Request toggle crossing into the core clock
   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
         req_seen_reg <= 1'b0;
      end else begin
         req_meta_reg <= req_tgl_reg;
         req_sync_reg <= req_meta_reg;
         req_seen_reg <= req_sync_reg;
      end
   end

   assign status_read = req_edge && !req_we_reg && (req_addr_reg == `OFS_EVENT_STATUS);
   // Fixed registers never take a write, so a stray host write cannot disturb them
   assign mask_write  = req_edge && req_we_reg && (req_addr_reg == `OFS_EVENT_MASK);

   // Read value is a snapshot of the cycle in which the status is cleared
   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         core_rdata_reg <= 8'h00;
      end else if (req_edge) begin
         core_rdata_reg <= read_map(req_addr_reg, mask_reg, status_reg);
      end
   end

   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         ack_tgl_reg <= 1'b0;
      end else if (req_edge) begin
         ack_tgl_reg <= ~ack_tgl_reg;
      end
   end

   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         mask_reg <= `RST_EVENT_MASK;
      end else if (mask_write) begin
         mask_reg <= req_wdata_reg[4:0];
      end
   end

   // Rp change only counts while attached as a sink
   always_comb begin
      event_set                    = '0;
      event_set[`BIT_RP_CHANGE]    = rp_change_evt_i && (attach_role_o == ROLE_SINK);
      event_set[`BIT_ROLE_CHANGE]  = role_change_evt_i;
      event_set[`BIT_ORIENT_FOUND] = orient_evt_i;
      event_set[`BIT_DEBUG_FOUND]  = debug_evt_i;
      event_set[`BIT_AUDIO_FOUND]  = audio_evt_i;
   end

   // A set in the clearing cycle wins so no event is lost
   always_comb begin
      status_next = status_reg;
      if (status_read) begin
         status_next = '0;
      end
      status_next = status_next | event_set;
   end

   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         status_reg <= `RST_EVENT_STATUS;
      end else begin
         status_reg <= status_next;
      end
   end

   // Attachment fields, one register per field
   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         attach_rp_o <= 2'h0;
      end else if (event_set[`BIT_RP_CHANGE]) begin
         attach_rp_o <= rp_adv_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         attach_role_o <= ROLE_NONE;
      end else begin
         attach_role_o <= role_update(attach_role_o, role_i, debug_evt_i, audio_evt_i,
                                      role_change_evt_i);
      end
   end

   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         attach_orient_o <= ORIENT_NONE;
      end else if (orient_evt_i) begin
         attach_orient_o <= orient_i;
      end
   end

   // Active low pin; built from the next status so it moves with the flag,
   // at the cost of a longer path from the event inputs
   always_ff @(posedge core_clk_i or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         int_n_o <= 1'b1;
      end else begin
         int_n_o <= ~|unmasked(status_next, mask_reg);
      end
   end

endmodule // cc_event_interrupt_regs

/* File: cc_event_cfg.svh */
`ifndef CC_EVENT_CFG_SVH
`define CC_EVENT_CFG_SVH

// Register offsets
`define OFS_FIXED_A      8'h13
`define OFS_FIXED_B      8'h14
`define OFS_FIXED_C      8'h15
`define OFS_FIXED_D      8'h16
`define OFS_FIXED_E      8'h17
`define OFS_EVENT_MASK   8'h18
`define OFS_EVENT_STATUS 8'h19

// Reset values
`define RST_FIXED_A      8'hA1
`define RST_FIXED_B      8'h1F
`define RST_FIXED_C      8'hC9
`define RST_FIXED_D      8'h51
`define RST_FIXED_E      8'h50
`define RST_EVENT_MASK   5'h1F
`define RST_EVENT_STATUS 5'h00

// Event bit positions in mask and status
`define BIT_RP_CHANGE    4
`define BIT_ROLE_CHANGE  3
`define BIT_ORIENT_FOUND 2
`define BIT_DEBUG_FOUND  1
`define BIT_AUDIO_FOUND  0
`define EVENT_BITS       5

`endif

/* File: cc_event_pkg.sv */
package cc_event_pkg;

   typedef logic [7:0] reg_byte_t;

   // Attachment role field codes, 101 to 111 are reserved
   typedef enum logic [2:0] {
      ROLE_NONE   = 3'h0,
      ROLE_SOURCE = 3'h1,
      ROLE_SINK   = 3'h2,
      ROLE_AUDIO  = 3'h3,
      ROLE_DEBUG  = 3'h4
   } role_e;

   // Orientation field codes, 11 is reserved
   typedef enum logic [1:0] {
      ORIENT_NONE     = 2'h0,
      ORIENT_NORMAL   = 2'h1,
      ORIENT_REVERSED = 2'h2
   } orient_e;

   // Link-side access state
   typedef enum logic {
      LINK_IDLE,
      LINK_WAIT
   } link_state_e;

endpackage

/* File: cc_event_checker_assertions.sv */
`timescale 1ns/1ps
module cc_event_checker (
   input wire logic                  core_clk_i,
   input wire logic                  nrst_i,
   input wire logic                  link_clk_i,
   input wire logic                  reg_wr_i,
   input wire logic                  reg_rd_i,
   input wire logic                  reg_rvalid_o,
   input wire logic                  reg_busy_o,
   input wire logic                  rp_change_evt_i,
   input wire logic [1:0]            rp_adv_i,
   input wire logic                  role_change_evt_i,
   input wire cc_event_pkg::role_e   role_i,
   input wire logic                  orient_evt_i,
   input wire cc_event_pkg::orient_e orient_i,
   input wire logic                  debug_evt_i,
   input wire logic                  audio_evt_i,
   input wire logic [1:0]            attach_rp_o,
   input wire cc_event_pkg::role_e   attach_role_o,
   input wire cc_event_pkg::orient_e attach_orient_o,
   input wire logic                  int_n_o
);
   import cc_event_pkg::*;
   chk_role_debug: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      debug_evt_i |=> attach_role_o == ROLE_DEBUG) else $error("debug role not set");
   chk_role_audio: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      audio_evt_i && !debug_evt_i |=> attach_role_o == ROLE_AUDIO) else $error("audio role");
   chk_role_new: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      role_change_evt_i && !debug_evt_i && !audio_evt_i |=> attach_role_o == $past(role_i))
      else $error("role field not updated");
   chk_orient_new: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      orient_evt_i |=> attach_orient_o == $past(orient_i)) else $error("orientation field");
   chk_rp_new: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      rp_change_evt_i && attach_role_o == ROLE_SINK |=> attach_rp_o == $past(rp_adv_i))
      else $error("rp field not updated");
   // Busy covers a mask write that unmasks a pending bit
   chk_int_cause: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $fell(int_n_o) |-> $past(rp_change_evt_i || role_change_evt_i || orient_evt_i
      || debug_evt_i || audio_evt_i || reg_busy_o)) else $error("interrupt without cause");
   chk_busy_take: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
      !reg_busy_o && (reg_wr_i || reg_rd_i) |=> reg_busy_o) else $error("request not taken");
   chk_busy_end: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
      $rose(reg_busy_o) |-> ##[1:12] !reg_busy_o) else $error("access never completes");
   chk_rvalid_pulse: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
      reg_rvalid_o |-> !reg_busy_o ##1 !reg_rvalid_o) else $error("read valid malformed");
endmodule // cc_event_checker
bind cc_event_interrupt_regs cc_event_checker cc_event_checker_inst (.core_clk_i, .nrst_i,
   .link_clk_i, .reg_wr_i, .reg_rd_i, .reg_rvalid_o, .reg_busy_o, .rp_change_evt_i, .rp_adv_i,
   .role_change_evt_i, .role_i, .orient_evt_i, .orient_i, .debug_evt_i, .audio_evt_i,
   .attach_rp_o, .attach_role_o, .attach_orient_o, .int_n_o);

/* File: cc_event_host.sv */
`timescale 1ns/1ps
module cc_event_host (
   input  wire logic       link_clk_i,
   input  wire logic       busy_i,
   input  wire logic       rvalid_i,
   input  wire logic [7:0] rdata_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o
);
   initial {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
      int n;
      q = 8'h00;
      ok = 1'b1;
      if (wr && a >= 8'h13 && a <= 8'h17) return;
      @(negedge link_clk_i);
      {wr_o, rd_o, addr_o, wdata_o} = {wr, !wr, a, d};
      @(posedge link_clk_i);
      @(negedge link_clk_i);
      // Released lines show the inverse so stale values cannot pass
      {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
      for (n = 0; n < 20 && busy_i !== 1'b0; n++) begin
         @(posedge link_clk_i);
         #1;
         if (rvalid_i === 1'b1) q = rdata_i;
      end
      ok = (n < 20);
   endtask
endmodule // cc_event_host

/* File: cc_event_interrupt_regs_test.sv */
`timescale 1ns/1ps
module cc_event_interrupt_regs_test;
   import cc_event_pkg::*;
   logic        core_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, wr, rd, rvalid, busy, int_n;
   logic [7:0]  addr, wdata, rdata, q;
   logic [4:0]  ev = 5'h00;
   logic [1:0]  rp_adv = 2'h0, a_rp;
   role_e       role = ROLE_NONE, a_role;
   orient_e     orient = ORIENT_NONE, a_orient;
   logic [31:0] seed = 32'h5CE74A06;
   int          fails = 0, n_tests = 0, m_mask = 31, m_stat = 0, m_rp = 0, m_role = 0, m_or = 0;
   int          fixed_q[$] = '{8'hA1, 8'h1F, 8'hC9, 8'h51, 8'h50};
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #17;
      forever #62.5 link_clk = ~link_clk;
   end
   cc_event_host cc_event_host_inst (.link_clk_i(link_clk), .busy_i(busy), .rvalid_i(rvalid),
      .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
   cc_event_interrupt_regs cc_event_interrupt_regs_inst (.core_clk_i(core_clk), .nrst_i(nrst),
      .link_clk_i(link_clk), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_busy_o(busy),
      .rp_change_evt_i(ev[4]), .rp_adv_i(rp_adv), .role_change_evt_i(ev[3]), .role_i(role),
      .orient_evt_i(ev[2]), .orient_i(orient), .debug_evt_i(ev[1]), .audio_evt_i(ev[0]),
      .attach_rp_o(a_rp), .attach_role_o(a_role), .attach_orient_o(a_orient), .int_n_o(int_n));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_out();
      return {2'(m_rp), 3'(m_role), ~|(5'(m_stat) & ~5'(m_mask)), 2'(m_or)};
   endfunction
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t register got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t outputs got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic ok;
      cc_event_host_inst.access(w, a, d, q, ok);
      if (!ok) begin
         fails++;
         finish_test();
      end
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      repeat (3) @(posedge link_clk);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 8'h13 + 8'(i), 8'h00);
         cmp_reg(q, i < 5 ? 8'(fixed_q[i]) : i == 5 ? 8'h1F : 8'h00);
      end
      $display("test reset values done");
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         if (seed[7]) begin
            bus(1'b1, 8'h18, seed[15:8]);
            m_mask = seed[12:8];
         end
         @(negedge core_clk);
         ev = seed[20:16];
         rp_adv = seed[22:21];
         role = role_e'(seed[26:24] % 5);
         orient = orient_e'(seed[28:27] % 3);
         m_stat = m_stat | {ev[4] && m_role == 2, ev[3:0]};
         if (ev[4] && m_role == 2) m_rp = rp_adv;
         m_role = ev[1] ? 4 : ev[0] ? 3 : ev[3] ? int'(role) : m_role;
         if (ev[2]) m_or = orient;
         @(negedge core_clk);
         ev = 5'h00;
         repeat (2) @(negedge core_clk);
         cmp_out({a_rp, a_role, int_n, a_orient}, exp_out());
         if (seed[30]) bus(1'b1, 8'h19, 8'hFF);
         bus(1'b0, 8'h18, 8'h00);
         cmp_reg(q, 8'(m_mask));
         bus(1'b0, 8'h19, 8'h00);
         cmp_reg(q, 8'(m_stat));
         m_stat = 0;
         repeat (3) @(negedge core_clk);
         cmp_out({a_rp, a_role, int_n, a_orient}, exp_out());
      end
      $display("test random events done");
      finish_test();
   end
endmodule // cc_event_interrupt_regs_test
